/* rtl/pot_ctrl_pkg.sv */
// package: constants and types for the potentiometer interface control block
package pot_ctrl_pkg;
  // ------------------------------------------------------------
  // command word layout
  // ------------------------------------------------------------
  localparam int WORD_BITS     = 16;
  localparam int CTRL_MSB      = 15;
  localparam int CTRL_LSB      = 12;
  localparam int ADDR_MSB      = 11;
  localparam int ADDR_LSB      = 8;
  localparam int DATA_MSB      = 7;
  localparam int DATA_LSB      = 0;
  localparam int BYTE_BITS     = 8;
  localparam int CHANNELS      = 4;
  localparam int WIPER_BITS    = 8;
  // ------------------------------------------------------------
  // commands decoded here
  // ------------------------------------------------------------
  localparam logic [3:0] CMD_NOP         = 4'h0;
  localparam logic [3:0] CMD_WRITE_WIPER = 4'h1;
  localparam logic [3:0] CMD_WRITE_INPUT = 4'h2;
  localparam logic [3:0] CMD_READBACK    = 4'h3;
  localparam logic [3:0] CMD_STORE_NV    = 4'h9;
  localparam logic [3:0] CMD_WRITE_NV    = 4'hb;
  localparam logic [3:0] ADDR_ALL        = 4'h8;
  // readback selectors (low data bits)
  localparam logic [1:0] RB_INPUT        = 2'h0;
  localparam logic [1:0] RB_NV           = 2'h1;
  localparam logic [1:0] RB_WIPER        = 2'h3;
  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] WIPER_RESET     = 8'h80;
  localparam logic [4:0] COUNT_RESET     = 5'h00;
  // ------------------------------------------------------------
  // spi frame states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    FR_IDLE  = 3'b001,
    FR_SHIFT = 3'b010,
    FR_DONE  = 3'b100
  } frame_e;
endpackage : pot_ctrl_pkg

/* rtl/pin_sync_if.sv */
// interface: synchronised pin levels and edge strobes
`timescale 1ns/1ps
interface pin_sync_if;
  logic sclk_fall;   // serial clock falling edge strobe
  logic sclk_rise;   // serial clock rising edge strobe
  logic frame_fall;  // frame sync went low
  logic frame_rise;  // frame sync went high
  logic frame_lvl;   // frame sync level
  logic sdi_lvl;     // serial data level
  logic load_fall;   // wiper load falling edge strobe
  logic reset_lvl_n; // hardware reset level, low active
  logic wp_lvl_n;    // write protect level, low active
  logic sel_i2c;     // interface select level
  modport src (output sclk_fall, sclk_rise, frame_fall, frame_rise, frame_lvl, sdi_lvl,
               load_fall, reset_lvl_n, wp_lvl_n, sel_i2c);
  modport dst (input sclk_fall, sclk_rise, frame_fall, frame_rise, frame_lvl, sdi_lvl,
               load_fall, reset_lvl_n, wp_lvl_n, sel_i2c);
endinterface : pin_sync_if

/* rtl/pin_sync.sv */
// module: two-stage synchronisers for all pins, edge detectors for serial clock, frame sync and wiper load
`timescale 1ns/1ps
module pin_sync
  import pot_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // raw pins
  input  wire logic sclk_pin,
  input  wire logic sdi_pin,
  input  wire logic frame_pin,
  input  wire logic load_pin_n,
  input  wire logic reset_pin_n,
  input  wire logic wp_pin_n,
  input  wire logic sel_pin,
  // synchronised view
  pin_sync_if.src   sy
);
  localparam int N = 7;
  // idle pin levels; select starts low so the mode output never flashes i2c
  localparam logic [N-1:0] PIN_IDLE = 7'h3d;
  logic [N-1:0] meta;
  logic [N-1:0] stab;
  logic [N-1:0] last;

  // two flip-flops per pin, then one more stage for edges
  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= PIN_IDLE;
      stab <= PIN_IDLE;
      last <= PIN_IDLE;
    end else begin
      meta <= {sel_pin, wp_pin_n, reset_pin_n, load_pin_n, frame_pin, sdi_pin, sclk_pin};
      stab <= meta;
      last <= stab;
    end
  end

  // edge strobes are one cycle wide per pin transition
  assign sy.sclk_fall   = last[0] & ~stab[0]; // RULE1
  assign sy.sclk_rise   = ~last[0] & stab[0];
  assign sy.sdi_lvl     = stab[1];
  assign sy.frame_lvl   = stab[2];
  assign sy.frame_fall  = last[2] & ~stab[2];
  assign sy.frame_rise  = ~last[2] & stab[2];
  assign sy.load_fall   = last[3] & ~stab[3]; // RULE19
  assign sy.reset_lvl_n = stab[4];            // RULE19
  assign sy.wp_lvl_n    = stab[5];            // RULE19
  assign sy.sel_i2c     = stab[6];
endmodule : pin_sync

/* rtl/pot_iface_ctrl.sv */
// module: serial port select, spi command path and wiper control pins
// Summary of operation
// RULE1 - i2c samples data on serial clock fall
// RULE2 - spi shifts input on serial clock fall
// RULE3 - select low means spi, high i2c
// RULE4 - host always drives the select pin
// RULE5 - data pin bidirectional i2c, input spi; here sda_oe is held low in both modes, so the pin is never driven
// RULE6 - i2c uses two address select inputs
// RULE7 - spi output on address pin, open drain
// RULE8 - frame low active, rise commits word
// RULE9 - write protect blocks changes, reload allowed
// RULE10 - write protect active at low level
// RULE11 - unused write protect tied high
// RULE12 - load fall copies pending inputs to wipers
// RULE13 - reset low reloads wipers from memory
// RULE14 - unused reset pin tied high
// RULE15 - sixteen bit word, control address data
// RULE16 - under sixteen edges discards the word
// RULE17 - count edges, need multiple of eight
// RULE18 - output enabled in frame, changes rising
// RULE19 - pins synchronised before edge detection
`timescale 1ns/1ps
module pot_iface_ctrl
  import pot_ctrl_pkg::*;
#(
  parameter int CH = CHANNELS
)(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // shared serial pins
  input  wire logic                  sclk_pin,
  input  wire logic                  sda_sdi_in,
  output logic                       sda_out,
  output logic                       sda_oe,
  input  wire logic                  bus_addr_sel_lo_frame_n,
  input  wire logic                  bus_addr_sel_hi_sdo_in,
  output logic                       bus_addr_sel_hi_sdo_out,
  output logic                       bus_addr_sel_hi_sdo_oe,
  // control pins
  input  wire logic                  interface_select,
  input  wire logic                  wiper_load_n,
  input  wire logic                  hw_reset_n,
  input  wire logic                  write_protect_n,
  // i2c address select levels and mode
  output logic [1:0]                 bus_addr_sel,
  output logic                       i2c_mode,
  // nonvolatile values and store requests
  input  wire logic [CH*WIPER_BITS-1:0] nv_value,
  output logic                       nv_write,
  output logic [1:0]                 nv_write_ch,
  output logic [WIPER_BITS-1:0]      nv_write_data,
  // wiper state and command status
  output logic [CH*WIPER_BITS-1:0]   wiper_register,
  output logic                       cmd_invalid
);
  pin_sync_if sy ();
  pin_sync u_sync (
    .clk         (clk),
    .rst         (rst),
    .sclk_pin    (sclk_pin),
    .sdi_pin     (sda_sdi_in),
    .frame_pin   (bus_addr_sel_lo_frame_n),
    .load_pin_n  (wiper_load_n),
    .reset_pin_n (hw_reset_n),
    .wp_pin_n    (write_protect_n),
    .sel_pin     (interface_select),
    .sy          (sy)
  );

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  frame_e                  frame;
  logic [WORD_BITS-1:0]    shreg;
  logic [4:0]              fall_cnt;
  logic [WORD_BITS-1:0]    out_sh;
  logic [WIPER_BITS-1:0]   input_reg [CH];
  logic [CH-1:0]           pending;
  logic                    cmd_go;
  logic [WORD_BITS-1:0]    cmd_word;
  logic                    spi_mode;
  logic                    protect;
  logic [1:0]              addr_meta;   // address pins, first flop
  logic [1:0]              addr_stab;   // address pins, settled

  assign spi_mode = ~sy.sel_i2c;   // RULE3
  assign protect  = ~sy.wp_lvl_n;  // RULE10

  function automatic logic [WIPER_BITS-1:0] ch_val(input logic [CH*WIPER_BITS-1:0] v, input int c);
    ch_val = v[c*WIPER_BITS +: WIPER_BITS];
  endfunction : ch_val

  function automatic logic hit(input logic [3:0] a, input int c);
    hit = (a == ADDR_ALL) || (a[1:0] == c[1:0]);
  endfunction : hit

  // mode and address select outputs; address pins pass two flops first
  always_ff @(posedge clk) begin
    if (rst) begin
      addr_meta    <= 2'h3;
      addr_stab    <= 2'h3;
      i2c_mode     <= 1'b0;
      bus_addr_sel <= 2'h0;
    end else begin
      addr_meta    <= {bus_addr_sel_hi_sdo_in, bus_addr_sel_lo_frame_n};
      addr_stab    <= addr_meta;
      i2c_mode     <= sy.sel_i2c;                     // RULE3
      bus_addr_sel <= sy.sel_i2c ? addr_stab : 2'h0; // RULE6
    end
  end

  // spi frame sequencing: shift on fall, commit on frame rise
  always_ff @(posedge clk) begin
    if (rst) begin
      frame    <= FR_IDLE;
      shreg    <= '0;
      fall_cnt <= COUNT_RESET;
      cmd_go   <= 1'b0;
      cmd_word <= '0;
      cmd_invalid <= 1'b0;
    end else begin
      cmd_go <= 1'b0;
      unique case (frame)
        FR_IDLE: begin
          if (spi_mode && sy.frame_fall) begin // RULE8
            frame    <= FR_SHIFT;
            fall_cnt <= COUNT_RESET;
          end
        end
        FR_SHIFT: begin
          if (sy.frame_rise) begin
            frame <= FR_DONE;
          end else if (sy.sclk_fall) begin
            shreg    <= {shreg[WORD_BITS-2:0], sy.sdi_lvl}; // RULE2 RULE15
            fall_cnt <= (fall_cnt == 5'h1f) ? 5'h10 : fall_cnt + 5'h01;
          end
        end
        FR_DONE: begin
          frame    <= FR_IDLE;
          fall_cnt <= COUNT_RESET; // RULE17
          if (fall_cnt >= 5'h10 && fall_cnt[2:0] == 3'h0) begin // RULE16 RULE17
            cmd_go      <= 1'b1;
            cmd_word    <= shreg; // RULE8
            cmd_invalid <= 1'b0;
          end else begin
            cmd_invalid <= 1'b1;
          end
        end
        default: frame <= FR_IDLE;
      endcase
    end
  end

  // wiper, input registers and pending load flags
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int c = 0; c < CH; c++) begin
        input_reg[c] <= WIPER_RESET;
      end
      wiper_register <= {CH{WIPER_RESET}};
      pending        <= '0;
    end else if (!sy.reset_lvl_n) begin
      wiper_register <= nv_value; // RULE13 RULE9
      pending        <= '0;
    end else begin
      if (sy.load_fall && !protect) begin // RULE12 RULE9
        for (int c = 0; c < CH; c++) begin
          if (pending[c]) wiper_register[c*WIPER_BITS +: WIPER_BITS] <= input_reg[c];
        end
        pending <= '0;
      end
      if (cmd_go && !protect) begin // RULE9
        for (int c = 0; c < CH; c++) begin
          if (hit(cmd_word[ADDR_MSB:ADDR_LSB], c)) begin
            if (cmd_word[CTRL_MSB:CTRL_LSB] == CMD_WRITE_WIPER)
              wiper_register[c*WIPER_BITS +: WIPER_BITS] <= cmd_word[DATA_MSB:DATA_LSB];
            if (cmd_word[CTRL_MSB:CTRL_LSB] == CMD_WRITE_INPUT) begin
              input_reg[c] <= cmd_word[DATA_MSB:DATA_LSB];
              pending[c]   <= 1'b1; // set wins over the load clear
            end
          end
        end
      end
    end
  end

  // nonvolatile store requests, blocked under protection
  always_ff @(posedge clk) begin
    if (rst) begin
      nv_write      <= 1'b0;
      nv_write_ch   <= 2'h0;
      nv_write_data <= '0;
    end else begin
      nv_write    <= 1'b0;
      nv_write_ch <= cmd_word[ADDR_LSB+1:ADDR_LSB];
      if (cmd_go && !protect && sy.reset_lvl_n) begin // RULE9
        if (cmd_word[CTRL_MSB:CTRL_LSB] == CMD_STORE_NV) begin
          nv_write      <= 1'b1;
          nv_write_data <= ch_val(wiper_register, int'(cmd_word[ADDR_LSB+1:ADDR_LSB]));
        end else if (cmd_word[CTRL_MSB:CTRL_LSB] == CMD_WRITE_NV) begin
          nv_write      <= 1'b1;
          nv_write_data <= cmd_word[DATA_MSB:DATA_LSB];
        end
      end
    end
  end

  // spi readback shifter: loaded by a readback command, shifted on rising edges
  always_ff @(posedge clk) begin
    if (rst) begin
      out_sh <= '0;
    end else if (cmd_go && cmd_word[CTRL_MSB:CTRL_LSB] == CMD_READBACK) begin
      unique case (cmd_word[1:0])
        RB_NV:    out_sh <= {8'h00, ch_val(nv_value, int'(cmd_word[ADDR_LSB+1:ADDR_LSB]))};
        RB_WIPER: out_sh <= {8'h00, ch_val(wiper_register, int'(cmd_word[ADDR_LSB+1:ADDR_LSB]))};
        default:  out_sh <= {8'h00, input_reg[cmd_word[ADDR_LSB+1:ADDR_LSB]]};
      endcase
    end else if (frame == FR_SHIFT && sy.sclk_rise) begin
      out_sh <= {out_sh[WORD_BITS-2:0], 1'b0}; // RULE18
    end
  end

  // open-drain output pin: only pulls low, enabled while frame low in spi mode
  always_ff @(posedge clk) begin
    if (rst) begin
      bus_addr_sel_hi_sdo_out <= 1'b0;
      bus_addr_sel_hi_sdo_oe  <= 1'b0;
      sda_out       <= 1'b0;
      sda_oe        <= 1'b0;
    end else begin
      bus_addr_sel_hi_sdo_out <= 1'b0;                                                   // RULE7
      bus_addr_sel_hi_sdo_oe  <= spi_mode && frame == FR_SHIFT && !out_sh[WORD_BITS-1]; // RULE7 RULE18
      sda_out       <= 1'b0;
      sda_oe        <= 1'b0; // RULE5 input-only here; nothing drives the data pin in either mode
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  sequence s_short_frame;
    frame == FR_DONE && fall_cnt < 5'h10;
  endsequence
  property p_short_invalid;
    @(posedge clk) disable iff (rst) s_short_frame |=> cmd_invalid && !cmd_go;
  endproperty
  a_short_invalid: assert property (p_short_invalid) else $error("short frame accepted"); // RULE16
  property p_odd_invalid;
    @(posedge clk) disable iff (rst) (frame == FR_DONE && fall_cnt[2:0] != 3'h0) |=> !cmd_go;
  endproperty
  a_odd_invalid: assert property (p_odd_invalid) else $error("non multiple of eight accepted"); // RULE17
  property p_reset_reload;
    @(posedge clk) disable iff (rst) !sy.reset_lvl_n |=> wiper_register == $past(nv_value);
  endproperty
  a_reset_reload: assert property (p_reset_reload) else $error("reset did not reload wipers"); // RULE13
  property p_protect_hold;
    @(posedge clk) disable iff (rst) (protect && sy.reset_lvl_n) |=> wiper_register == $past(wiper_register);
  endproperty
  a_protect_hold: assert property (p_protect_hold) else $error("wiper changed under protection"); // RULE9
  property p_protect_nv;
    @(posedge clk) disable iff (rst) (cmd_go && protect) |=> !nv_write;
  endproperty
  a_protect_nv: assert property (p_protect_nv) else $error("nv write under protection"); // RULE10
  property p_load_clears;
    @(posedge clk) disable iff (rst) (sy.load_fall && !protect && sy.reset_lvl_n && !cmd_go) |=> pending == '0;
  endproperty
  a_load_clears: assert property (p_load_clears) else $error("load left pending flags"); // RULE12
  property p_sdo_idle;
    @(posedge clk) disable iff (rst) (frame != FR_SHIFT) |=> !bus_addr_sel_hi_sdo_oe;
  endproperty
  a_sdo_idle: assert property (p_sdo_idle) else $error("output driven outside frame"); // RULE18
  property p_od_low;
    @(posedge clk) disable iff (rst) bus_addr_sel_hi_sdo_oe |-> !bus_addr_sel_hi_sdo_out;
  endproperty
  a_od_low: assert property (p_od_low) else $error("open drain drove high"); // RULE7
  property p_i2c_no_frame;
    @(posedge clk) disable iff (rst) (sy.sel_i2c && frame == FR_IDLE) |=> frame == FR_IDLE;
  endproperty
  a_i2c_no_frame: assert property (p_i2c_no_frame) else $error("spi frame in i2c mode"); // RULE3
endmodule : pot_iface_ctrl

/* tb/spi_host.sv */
// partner: spi host that sends frames and captures the open-drain output
`timescale 1ns/1ps
module spi_host (
  // clock
  input  wire logic        clk,
  // open-drain line as seen through the pull-up
  input  wire logic        sdo,
  // host pins
  output logic             sclk,
  output logic             sdi,
  output logic             frame_n,
  output logic [15:0]      rd
);
  // idle: clock parked high, frame released
  initial begin
    sclk    = 1'b1;
    sdi     = 1'b0;
    frame_n = 1'b1;
    rd      = 16'h0000;
  end
  // ----------------------------------------
  // one frame of n bits, msb first
  // ----------------------------------------
  task automatic xfer(input logic [31:0] w, input int n);
    rd      <= 16'h0000;
    frame_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sdi <= w[i];
      repeat (4) @(posedge clk);
      sclk <= 1'b0;
      repeat (4) @(posedge clk);
      rd   <= {rd[14:0], sdo};      // sampled late in the low phase
      sclk <= 1'b1;
    end
    repeat (4) @(posedge clk);
    frame_n <= 1'b1;
    sdi     <= ~sdi;               // released data line shows no stale bit
    repeat (4) @(posedge clk);
  endtask : xfer
endmodule : spi_host

/* tb/tb.sv */
// testbench: spi frames, wiper load, protect, hardware reset and select checks
`timescale 1ns/1ps
module tb;
  import pot_ctrl_pkg::*;
  // ----------------------------------------
  // pins, expected state and counters
  // ----------------------------------------
  logic        clk              = 1'b0;
  logic        rst              = 1'b1;
  logic        interface_select = 1'b0;
  logic        wiper_load_n     = 1'b1;
  logic        hw_reset_n       = 1'b1;
  logic        write_protect_n  = 1'b1;
  logic        a0               = 1'b1;
  logic        a1               = 1'b1;
  logic [31:0] nv_value         = 32'h0;
  logic [31:0] ew               = {4{WIPER_RESET}};
  logic        einv             = 1'b0;
  logic [2:0]  emode            = 3'h0;
  logic [11:0] env              = 12'h000;
  logic [11:0] nv_cap           = 12'h000;
  logic [31:0] s                = 32'h00011732;
  int          error_cnt        = 0;
  int          n_compared       = 0;
  int          cyc              = 0;
  int          bad[3]           = '{8, 15, 20};
  logic [67:0] q_e[$];
  logic [67:0] q_m[$];
  logic        sclk, sdi, frame_n, sdo, sda_out, sda_oe, sdo_oe, i2c_mode, cmd_invalid;
  logic        sdo_out, nv_write;
  logic [1:0]  nv_write_ch;
  logic [7:0]  nv_write_data;
  logic [1:0]  bus_addr_sel;
  logic [31:0] wiper_register;
  logic [15:0] rd;
  event        chk;

  always #50 clk = ~clk;
  // open-drain output with pull-up
  assign sdo = ~sdo_oe;
  // capture every store request pulse: running count, channel, data
  always @(posedge clk) begin
    if (nv_write) begin
      nv_cap <= {nv_cap[11:10] + 2'h1, nv_write_ch, nv_write_data};
    end
  end

  pot_iface_ctrl i_dut (.clk(clk), .rst(rst), .sclk_pin(sclk), .sda_sdi_in(sda_oe ? sda_out : sdi),
    .sda_out(sda_out), .sda_oe(sda_oe), .bus_addr_sel_lo_frame_n(frame_n & a0), .bus_addr_sel_hi_sdo_in(sdo & a1),
    .bus_addr_sel_hi_sdo_out(sdo_out), .bus_addr_sel_hi_sdo_oe(sdo_oe), .interface_select(interface_select),
    .wiper_load_n(wiper_load_n), .hw_reset_n(hw_reset_n), .write_protect_n(write_protect_n),
    .bus_addr_sel(bus_addr_sel), .i2c_mode(i2c_mode), .nv_value(nv_value), .nv_write(nv_write),
    .nv_write_ch(nv_write_ch), .nv_write_data(nv_write_data), .wiper_register(wiper_register),
    .cmd_invalid(cmd_invalid));

  spi_host i_host (.clk(clk), .sdo(sdo), .sclk(sclk), .sdi(sdi), .frame_n(frame_n), .rd(rd));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] rnd();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s[7:0];
  endfunction : rnd

  task automatic send(input logic [31:0] w, input int n);
    i_host.xfer(w, n);
    repeat (6) @(posedge clk);
  endtask : send

  // note the expectation, then let the watcher compare settled outputs
  task automatic put(input logic ci, input logic [15:0] erd, input logic cr);
    #1;
    q_e.push_back({env, 2'b00, ew, einv, emode, 2'b00, erd});
    q_m.push_back({{46{1'b1}}, ci, 5'h1f, {16{cr}}});
    -> chk;
    @(posedge clk);
  endtask : put

  task automatic complete_run();
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  // watcher: oldest note against present outputs
  always @(chk) begin : watch
    logic [67:0] e, m, o;
    e = q_e.pop_front();
    m = q_m.pop_front();
    o = {nv_cap, sda_out, sdo_out, wiper_register, cmd_invalid, i2c_mode, bus_addr_sel, sda_oe, sdo_oe, rd};
    n_compared++;
    if ((o & m) !== (e & m)) begin
      error_cnt++;
      $display("BAD %0t got %h want %h", $time, o & m, e & m);
    end
  end

  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      error_cnt++;
      complete_run();
    end
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin : main
    logic [7:0] d;
    logic [7:0] d2;
    repeat (12) @(posedge clk);
    rst      <= 1'b0;
    nv_value <= {rnd(), rnd(), rnd(), rnd()};
    repeat (4) @(posedge clk);
    put(1'b1, 16'h0, 1'b0);
    for (int c = 0; c < 4; c++) begin
      d = rnd();
      send({CMD_WRITE_WIPER, c[3:0], d}, 16);
      ew[8*c +: 8] = d;
      put(1'b1, 16'h0, 1'b0);
    end
    foreach (bad[k]) begin
      send({CMD_WRITE_WIPER, 4'h0, 8'h00}, bad[k]);
      einv = 1'b1;
      put(1'b1, 16'h0, 1'b0);
    end
    d = rnd();
    send({8'ha5, CMD_WRITE_WIPER, 4'h2, d}, 24);
    ew[23:16] = d;
    einv      = 1'b0;
    put(1'b1, 16'h0, 1'b0);
    d = rnd();
    send({CMD_WRITE_WIPER, ADDR_ALL, d}, 16);
    ew = {4{d}};
    put(1'b1, 16'h0, 1'b0);
    // readback of wiper, nonvolatile value, then input register, shifted out on the next frame
    for (int k = 0; k < 3; k++) begin
      send({CMD_READBACK, 4'h1, 6'h00, (k == 0) ? RB_WIPER : (k == 1) ? RB_NV : RB_INPUT}, 16);
      send(32'h0, 16);
      put(1'b1, {8'h00, (k == 0) ? ew[15:8] : (k == 1) ? nv_value[15:8] : WIPER_RESET}, 1'b1);
    end
    d  = rnd();
    d2 = rnd();
    send({CMD_WRITE_INPUT, 4'h1, d}, 16);
    send({CMD_WRITE_INPUT, 4'h3, d2}, 16);
    put(1'b1, 16'h0, 1'b0);
    wiper_load_n <= 1'b0;
    repeat (6) @(posedge clk);
    ew[15:8]  = d;
    ew[31:24] = d2;
    put(1'b1, 16'h0, 1'b0);
    wiper_load_n    <= 1'b1;
    write_protect_n <= 1'b0;
    send({CMD_WRITE_WIPER, 4'h0, rnd()}, 16);
    put(1'b0, 16'h0, 1'b0);
    send({CMD_WRITE_NV, 4'h1, rnd()}, 16);
    put(1'b0, 16'h0, 1'b0);
    send({CMD_WRITE_INPUT, 4'h0, rnd()}, 16);
    wiper_load_n <= 1'b0;
    repeat (6) @(posedge clk);
    put(1'b0, 16'h0, 1'b0);
    wiper_load_n <= 1'b1;
    hw_reset_n   <= 1'b0;
    repeat (6) @(posedge clk);
    ew = nv_value;
    put(1'b0, 16'h0, 1'b0);
    hw_reset_n       <= 1'b1;
    write_protect_n  <= 1'b1;
    interface_select <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      {a1, a0} <= k[1:0];
      repeat (6) @(posedge clk);
      emode = {1'b1, k[1:0]};
      put(1'b0, 16'h0, 1'b0);
    end
    {a1, a0} <= 2'b11;
    send({CMD_WRITE_WIPER, 4'h0, rnd()}, 16);
    emode = 3'b111;
    put(1'b0, 16'h0, 1'b0);
    interface_select <= 1'b0;
    repeat (6) @(posedge clk);
    d = rnd();
    send({CMD_WRITE_WIPER, 4'h3, d}, 16);
    ew[31:24] = d;
    emode     = 3'h0;
    put(1'b1, 16'h0, 1'b0);
    // store requests once protection is released
    send({CMD_STORE_NV, 4'h3, 8'h00}, 16);
    env = {2'h1, 2'h3, ew[31:24]};
    put(1'b1, 16'h0, 1'b0);
    d = rnd();
    send({CMD_WRITE_NV, 4'h0, d}, 16);
    env = {2'h2, 2'h0, d};
    put(1'b1, 16'h0, 1'b0);
    complete_run();
  end
endmodule : tb
